// ---- core/iwdtw_pkg.sv ----
// Constants, field layouts and helpers of the windowed independent watchdog
package iwdtw_pkg;

   // ****************************************
   // Clocking
   // ****************************************
   localparam int CLK_HZ = 125_000_000;
   localparam int SRC_CLK_HZ = 15_000;
   // Bus clocks per watchdog source clock period, rounded down
   localparam int SRC_DIV = CLK_HZ / SRC_CLK_HZ;
   localparam int COUNT_W = 11;
   localparam int THR_W = 12;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_REFRESH = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RSTCTRL = 8'h0C;
   localparam logic [7:0] ADDR_STOPCTRL = 8'h10;
   localparam logic [7:0] REFRESH_FIRST = 8'h00;
   localparam logic [7:0] REFRESH_SECOND = 8'hFF;

   // Control and status fields
   localparam int CTRL_TOPS_LSB = 0;
   localparam int CTRL_CKS_LSB = 4;
   localparam int CTRL_RPES_LSB = 8;
   localparam int CTRL_RPSS_LSB = 12;
   localparam logic [15:0] CTRL_RESET = 16'h3303;
   localparam int STAT_UFLOW_BIT = 14;
   localparam int STAT_REFERR_BIT = 15;
   localparam int RSTIRQ_BIT = 7;
   localparam int LOWPOWER_COUNT_STOP_BIT = 7;
   localparam logic RSTIRQ_RESET = 1'b1;

   // Option word 0 fields
   localparam int OPT_AUTO_BIT = 1;
   localparam int OPT_TOPS_LSB = 2;
   localparam int OPT_CKS_LSB = 4;
   localparam int OPT_RPES_LSB = 8;
   localparam int OPT_RPSS_LSB = 10;
   localparam int OPT_RSTIRQ_BIT = 12;
   localparam int OPT_LOWPOWER_COUNT_STOP_BIT = 14;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [0:0] {
      MODE_REG = 1'b0,
      MODE_AUTO = 1'b1
   } iwdtw_mode_t;

   localparam logic [3:0] CKS_DIV1 = 4'h0;
   localparam logic [3:0] CKS_DIV16 = 4'h2;
   localparam logic [3:0] CKS_DIV32 = 4'h3;
   localparam logic [3:0] CKS_DIV64 = 4'h4;
   localparam logic [3:0] CKS_DIV128 = 4'hF;
   localparam logic [3:0] CKS_DIV256 = 4'h5;

   localparam logic [10:0] TOP_128 = 11'h07F;
   localparam logic [10:0] TOP_512 = 11'h1FF;
   localparam logic [10:0] TOP_1024 = 11'h3FF;
   localparam logic [10:0] TOP_2048 = 11'h7FF;

   // Initial count for a timeout period code
   function automatic logic [10:0] top_count(input logic [1:0] tops);
      case (tops)
         2'h0: return TOP_128;
         2'h1: return TOP_512;
         2'h2: return TOP_1024;
         default: return TOP_2048;
      endcase
   endfunction

   // Undefined codes fall back to no division
   function automatic logic [8:0] div_ratio(input logic [3:0] cks);
      case (cks)
         CKS_DIV16: return 9'h010;
         CKS_DIV32: return 9'h020;
         CKS_DIV64: return 9'h040;
         CKS_DIV128: return 9'h080;
         CKS_DIV256: return 9'h100;
         default: return 9'h001;
      endcase
   endfunction

   // Count threshold of a window edge, in quarters of the period
   function automatic logic [11:0] win_thr(input logic [1:0] code,
                                           input logic [10:0] top,
                                           input logic is_open);
      logic [11:0] qtr;
      logic [2:0] q;
      qtr = ({1'b0, top} + 12'h001) >> 2;
      if (is_open && code == 2'h3) begin
         q = 3'h4;
      end else begin
         q = 3'h3 - {1'b0, code};
      end
      return 12'(qtr * q);
   endfunction

endpackage

// ---- core/iwdtw_prescaler.sv ----
// Source clock enable and selectable divider of the watchdog counter
`timescale 1ns/100ps
module iwdtw_prescaler #(
   parameter int SRC_DIV = iwdtw_pkg::SRC_DIV,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic clear,
   input wire logic enable,
   input wire logic [3:0] ratio_sel,
   // Counter step, one cycle
   output logic tick
);

   typedef struct packed {
      logic [CNT_W-1:0] src_cnt;
      logic [8:0] div_cnt;
      logic tick;
   } iwdtw_presc_t;

   localparam logic [CNT_W-1:0] SRC_LAST = CNT_W'(SRC_DIV - 1);

   iwdtw_presc_t s;
   iwdtw_presc_t next_s;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (clear) begin
         // Restart both stages so a new period starts clean
         next_s.src_cnt = '0;
         next_s.div_cnt = '0;
      end else if (enable) begin
         if (s.src_cnt == SRC_LAST) begin
            next_s.src_cnt = '0;
            if (s.div_cnt == iwdtw_pkg::div_ratio(ratio_sel) - 9'h001) begin
               next_s.div_cnt = '0;
               next_s.tick = 1'b1;
            end else begin
               next_s.div_cnt = s.div_cnt + 9'h001;
            end
         end else begin
            next_s.src_cnt = s.src_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule

// ---- core/iwdtw_top.sv ----
// Windowed independent watchdog with AXI4-Lite register access
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module iwdtw_top #(
   parameter int SRC_DIV = iwdtw_pkg::SRC_DIV
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Device side
   input wire logic [15:0] option_setting_word0,
   input wire logic lowpower_mode,
   output logic reset_request,
   output logic irq_request,
   output logic sleep_count_stop
);

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic cfg_loaded;
      iwdtw_pkg::iwdtw_mode_t mode;
      logic [15:0] ctrl;
      logic rstirq_reg;
      logic lowpower_count_stop_reg;
      logic [3:0] eff_cks;
      logic [1:0] eff_tops;
      logic [1:0] eff_rpss;
      logic [1:0] eff_rpes;
      logic eff_rstirq;
      logic eff_lowpower_count_stop;
      logic running;
      logic [10:0] count;
      logic armed;
      logic uflow_flag;
      logic referr_flag;
      logic rst_req;
      logic irq_req;
      logic presc_clr;
      logic sleep_stop;
   } iwdtw_state_t;

   localparam iwdtw_state_t S_RST = '{
      ctrl: iwdtw_pkg::CTRL_RESET,
      rstirq_reg: iwdtw_pkg::RSTIRQ_RESET,
      mode: iwdtw_pkg::MODE_REG,
      default: '0
   };

   iwdtw_state_t s;
   iwdtw_state_t next_s;
   logic tick;
   logic halted;
   logic do_write;
   logic refresh_ok;
   logic permitted;
   logic event_hit;
   logic [11:0] open_thr;
   logic [11:0] close_thr;

   // ****************************************
   // Counter clock
   // ****************************************
   iwdtw_prescaler #(
      .SRC_DIV(SRC_DIV)
   ) i_iwdtw_prescaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(s.presc_clr),
      .enable(s.running && !halted),
      .ratio_sel(s.eff_cks),
      .tick(tick)
   );

   // Low-power stop only when the setting allows it
   assign halted = s.eff_lowpower_count_stop && lowpower_mode;

   // ****************************************
   // Window and refresh decode
   // ****************************************
   assign open_thr = iwdtw_pkg::win_thr(s.eff_rpss,
      iwdtw_pkg::top_count(s.eff_tops), 1'b1);
   assign close_thr = iwdtw_pkg::win_thr(s.eff_rpes,
      iwdtw_pkg::top_count(s.eff_tops), 1'b0);
   assign permitted = ({1'b0, s.count} < open_thr)
      && ({1'b0, s.count} >= close_thr);
   assign do_write = s.aw_held && s.w_held && !s.bvalid;
   assign refresh_ok = do_write && s.aw_addr == iwdtw_pkg::ADDR_REFRESH
      && s.wstrb[0] && s.armed
      && s.wdata[7:0] == iwdtw_pkg::REFRESH_SECOND;
   // A refresh landing on the underflow tick wins over the underflow
   assign event_hit = (s.running && !halted && tick && s.count == '0
      && !refresh_ok) || (refresh_ok && s.running && !permitted);

   always_comb begin
      next_s = s;
      next_s.rst_req = 1'b0;
      next_s.irq_req = 1'b0;
      next_s.presc_clr = 1'b0;
      next_s.sleep_stop = s.eff_lowpower_count_stop && lowpower_mode;

      // Option word is sampled once, on the first cycle out of reset
      if (!s.cfg_loaded) begin
         next_s.cfg_loaded = 1'b1;
         if (option_setting_word0[iwdtw_pkg::OPT_AUTO_BIT]) begin
            next_s.mode = iwdtw_pkg::MODE_AUTO;
            next_s.eff_cks = option_setting_word0[
               iwdtw_pkg::OPT_CKS_LSB +: 4];
            next_s.eff_tops = option_setting_word0[
               iwdtw_pkg::OPT_TOPS_LSB +: 2];
            next_s.eff_rpss = option_setting_word0[
               iwdtw_pkg::OPT_RPSS_LSB +: 2];
            next_s.eff_rpes = option_setting_word0[
               iwdtw_pkg::OPT_RPES_LSB +: 2];
            next_s.eff_rstirq = option_setting_word0[
               iwdtw_pkg::OPT_RSTIRQ_BIT];
            next_s.eff_lowpower_count_stop = option_setting_word0[
               iwdtw_pkg::OPT_LOWPOWER_COUNT_STOP_BIT];
            next_s.count = iwdtw_pkg::top_count(option_setting_word0[
               iwdtw_pkg::OPT_TOPS_LSB +: 2]);
            next_s.running = 1'b1;
            next_s.presc_clr = 1'b1;
         end
      end

      // ****************************************
      // AXI4-Lite channels
      // ****************************************
      if (awvalid && awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_held = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (do_write) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = iwdtw_pkg::RESP_OKAY;
         if (s.aw_addr == iwdtw_pkg::ADDR_REFRESH) begin
            // A byte-0 refresh write of anything but the first value disarms the sequence
            if (s.wstrb[0]) begin
               next_s.armed = s.wdata[7:0] == iwdtw_pkg::REFRESH_FIRST;
            end
         end else if (s.aw_addr == iwdtw_pkg::ADDR_CONTROL) begin
            // Settings are fixed by the option word in auto mode
            if (s.mode == iwdtw_pkg::MODE_REG) begin
               if (s.wstrb[0]) begin
                  next_s.ctrl[7:0] = s.wdata[7:0];
               end
               if (s.wstrb[1]) begin
                  next_s.ctrl[15:8] = s.wdata[15:8];
               end
            end
         end else if (s.aw_addr == iwdtw_pkg::ADDR_STATUS) begin
            if (s.wstrb[1]) begin
               if (!s.wdata[iwdtw_pkg::STAT_UFLOW_BIT]) begin
                  next_s.uflow_flag = 1'b0;
               end
               if (!s.wdata[iwdtw_pkg::STAT_REFERR_BIT]) begin
                  next_s.referr_flag = 1'b0;
               end
            end
         end else if (s.aw_addr == iwdtw_pkg::ADDR_RSTCTRL) begin
            if (s.wstrb[0] && s.mode == iwdtw_pkg::MODE_REG) begin
               next_s.rstirq_reg = s.wdata[iwdtw_pkg::RSTIRQ_BIT];
            end
         end else if (s.aw_addr == iwdtw_pkg::ADDR_STOPCTRL) begin
            if (s.wstrb[0] && s.mode == iwdtw_pkg::MODE_REG) begin
               next_s.lowpower_count_stop_reg = s.wdata[iwdtw_pkg::LOWPOWER_COUNT_STOP_BIT];
            end
         end else begin
            next_s.bresp = iwdtw_pkg::RESP_SLVERR;
         end
      end

      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = iwdtw_pkg::RESP_OKAY;
         next_s.rdata = '0;
         if (araddr == iwdtw_pkg::ADDR_REFRESH) begin
            next_s.rdata = '0;
         end else if (araddr == iwdtw_pkg::ADDR_CONTROL) begin
            next_s.rdata[15:0] = s.ctrl;
         end else if (araddr == iwdtw_pkg::ADDR_STATUS) begin
            next_s.rdata[10:0] = s.count;
            next_s.rdata[iwdtw_pkg::STAT_UFLOW_BIT] = s.uflow_flag;
            next_s.rdata[iwdtw_pkg::STAT_REFERR_BIT] =
               s.referr_flag;
         end else if (araddr == iwdtw_pkg::ADDR_RSTCTRL) begin
            next_s.rdata[iwdtw_pkg::RSTIRQ_BIT] = s.rstirq_reg;
         end else if (araddr == iwdtw_pkg::ADDR_STOPCTRL) begin
            next_s.rdata[iwdtw_pkg::LOWPOWER_COUNT_STOP_BIT] = s.lowpower_count_stop_reg;
         end else begin
            next_s.rresp = iwdtw_pkg::RESP_SLVERR;
         end
      end

      // ****************************************
      // Down-counter
      // ****************************************
      if (s.running && !halted && tick && s.count != '0) begin
         next_s.count = s.count - 11'h001;
      end
      if (refresh_ok) begin
         if (s.running && permitted) begin
            next_s.count = iwdtw_pkg::top_count(s.eff_tops);
            next_s.presc_clr = 1'b1;
         end
         // Register mode takes fresh settings on every good refresh
         if (s.mode == iwdtw_pkg::MODE_REG && (!s.running || permitted))
         begin
            next_s.eff_cks = s.ctrl[iwdtw_pkg::CTRL_CKS_LSB +: 4];
            next_s.eff_tops = s.ctrl[iwdtw_pkg::CTRL_TOPS_LSB +: 2];
            next_s.eff_rpss = s.ctrl[iwdtw_pkg::CTRL_RPSS_LSB +: 2];
            next_s.eff_rpes = s.ctrl[iwdtw_pkg::CTRL_RPES_LSB +: 2];
            next_s.eff_rstirq = s.rstirq_reg;
            next_s.eff_lowpower_count_stop = s.lowpower_count_stop_reg;
            next_s.count = iwdtw_pkg::top_count(
               s.ctrl[iwdtw_pkg::CTRL_TOPS_LSB +: 2]);
            next_s.running = 1'b1;
            next_s.presc_clr = 1'b1;
         end
      end
      if (event_hit) begin
         next_s.running = 1'b0;
         if (refresh_ok) begin
            next_s.referr_flag = 1'b1;
         end else begin
            next_s.uflow_flag = 1'b1;
         end
         if (s.eff_rstirq) begin
            next_s.rst_req = 1'b1;
         end else begin
            next_s.irq_req = 1'b1;
            // Auto mode resumes in the same cycle the interrupt request goes out
            if (s.mode == iwdtw_pkg::MODE_AUTO) begin
               next_s.count = iwdtw_pkg::top_count(s.eff_tops);
               next_s.running = 1'b1;
               next_s.presc_clr = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= S_RST;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign awready = !s.aw_held && !s.bvalid;
   assign wready = !s.w_held && !s.bvalid;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = !s.rvalid;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign reset_request = s.rst_req;
   assign irq_request = s.irq_req;
   assign sleep_count_stop = s.sleep_stop;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   auto_start_run_a: assert property (
      $rose(s.cfg_loaded) && s.mode == iwdtw_pkg::MODE_AUTO |-> s.running)
      else $error("auto start did not run");
   reg_start_run_a: assert property (
      refresh_ok && !s.running && s.mode == iwdtw_pkg::MODE_REG |=>
      s.running && s.count == iwdtw_pkg::top_count(s.eff_tops))
      else $error("register start failed");
   event_stops_a: assert property (
      event_hit && s.eff_rstirq |=> !s.running [*2])
      else $error("count kept running after event");
   window_error_a: assert property (
      refresh_ok && s.running && !permitted |=>
      s.referr_flag && (s.rst_req || s.irq_req))
      else $error("window error not flagged");
   output_select_a: assert property (
      event_hit |=> (s.rst_req == $past(s.eff_rstirq))
      && (s.irq_req == !$past(s.eff_rstirq)))
      else $error("wrong event output");
   lowpower_hold_a: assert property (
      s.running && halted && !refresh_ok && !event_hit |=>
      s.count == $past(s.count))
      else $error("count moved in low power");
   refresh_reload_a: assert property (
      refresh_ok && s.running && permitted |=>
      s.count == iwdtw_pkg::top_count(s.eff_tops) && !s.rst_req)
      else $error("refresh did not reload");
   refresh_pair_a: assert property (
      !(do_write && s.aw_addr == iwdtw_pkg::ADDR_REFRESH && s.wstrb[0]
      && s.wdata[7:0] == iwdtw_pkg::REFRESH_FIRST) |=> !$rose(s.armed))
      else $error("sequence armed without a first write");
   auto_resume_a: assert property (
      event_hit && !s.eff_rstirq && s.mode == iwdtw_pkg::MODE_AUTO |=>
      s.running && s.irq_req)
      else $error("auto mode did not resume");

endmodule

// ---- test/tb.sv ----
// Self-checking bench of the windowed watchdog over its register bus
`timescale 1ns/100ps
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic lowpower_mode = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [15:0] option_setting_word0 = 16'h0000;
   logic awready, wready, bvalid, arready, rvalid;
   logic reset_request, irq_request, sleep_count_stop;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, a, b;
   logic [1:0] rs;
   logic gi, gr;
   int fails = 0;
   int num_checks = 0;
   int n_irq = 0;
   int n_rst = 0;
   int b_irq = 0;
   int b_rst = 0;
   // Two-cycle source tick keeps the longest timeout short
   iwdtw_top #(.SRC_DIV(2)) i_iwdtw_top (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .option_setting_word0(option_setting_word0),
      .lowpower_mode(lowpower_mode), .reset_request(reset_request),
      .irq_request(irq_request), .sleep_count_stop(sleep_count_stop));
   always #4 aclk = ~aclk;
   // Pulses are counted so none is lost while a bus task is busy
   always @(posedge aclk) begin
      if (irq_request) begin
         n_irq <= n_irq + 1;
      end
      if (reset_request) begin
         n_rst <= n_rst + 1;
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic hang();
      fails++;
      $display("mismatch handshake expected answer seen none");
      stop_test();
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int n;
      logic tb_;
      tb_ = 1'b0;
      n = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= ad;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      while (!tb_) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) begin
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
         end
         if (bvalid && bready) begin
            tb_ = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
         if (n > 50) hang();
      end
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      logic tr;
      tr = 1'b0;
      n = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= ad;
      rready <= 1'b1;
      while (!tr) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
         if (rvalid && rready) begin
            tr = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
         if (n > 50) hang();
      end
   endtask
   task automatic refresh();
      wr(iwdtw_pkg::ADDR_REFRESH, 32'h00, 4'h1, rs);
      wr(iwdtw_pkg::ADDR_REFRESH, 32'hFF, 4'h1, rs);
   endtask
   // Reports pulses since the last call; both flags low if none came
   task automatic wait_evt(input int lim);
      for (int i = 0; i < lim && n_irq == b_irq && n_rst == b_rst;
           i++) begin
         @(posedge aclk);
      end
      gi = n_irq != b_irq;
      gr = n_rst != b_rst;
      b_irq = n_irq;
      b_rst = n_rst;
   endtask
   task automatic do_reset(input logic [15:0] w);
      @(posedge aclk);
      aresetn <= 1'b0;
      option_setting_word0 <= w;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic stable(input int cyc);
      rd(iwdtw_pkg::ADDR_STATUS, a, rs);
      repeat (cyc) @(posedge aclk);
      rd(iwdtw_pkg::ADDR_STATUS, b, rs);
      chk("count held", a & 32'h7FF, b & 32'h7FF);
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      logic [10:0] tops [4];
      tops = '{11'h07F, 11'h1FF, 11'h3FF, 11'h7FF};
      do_reset(16'h0000);
      rd(iwdtw_pkg::ADDR_CONTROL, a, rs);
      chk("control reset", 32'h3303, a);
      rd(iwdtw_pkg::ADDR_RSTCTRL, a, rs);
      chk("reset select reset", 32'h80, a);
      rd(iwdtw_pkg::ADDR_STOPCTRL, a, rs);
      chk("stop control reset", 32'h0, a);
      rd(iwdtw_pkg::ADDR_STATUS, a, rs);
      chk("status flags", 32'h0, a & 32'hC000);
      rd(8'h40, a, rs);
      chk("unmapped read resp", 32'(iwdtw_pkg::RESP_SLVERR), 32'(rs));
      chk("unmapped read data", 32'h0, a);
      wr(8'h40, 32'h0, 4'hF, rs);
      chk("unmapped write", 32'(iwdtw_pkg::RESP_SLVERR), 32'(rs));
      $display("test reset values done");
      wr(iwdtw_pkg::ADDR_RSTCTRL, 32'h0, 4'hF, rs);
      wr(iwdtw_pkg::ADDR_CONTROL, 32'h3300, 4'hF, rs);
      stable(20);
      chk("not started", 32'h0, b & 32'hC000);
      wr(iwdtw_pkg::ADDR_REFRESH, 32'h00, 4'h1, rs);
      wr(iwdtw_pkg::ADDR_REFRESH, 32'h55, 4'h1, rs);
      wr(iwdtw_pkg::ADDR_REFRESH, 32'hFF, 4'h1, rs);
      stable(20);
      refresh();
      wait_evt(1000);
      chk("underflow irq", 32'h2, {gi, gr});
      rd(iwdtw_pkg::ADDR_STATUS, a, rs);
      chk("underflow flag", 32'h4000, a & 32'hC000);
      stable(40);
      $display("test register start done");
      wr(iwdtw_pkg::ADDR_STATUS, 32'h0, 4'h2, rs);
      wr(iwdtw_pkg::ADDR_CONTROL, 32'h0300, 4'hF, rs);
      refresh();
      refresh();
      wait_evt(20);
      chk("window error irq", 32'h2, {gi, gr});
      rd(iwdtw_pkg::ADDR_STATUS, a, rs);
      chk("error flag", 32'h8000, a & 32'hC000);
      stable(20);
      wr(iwdtw_pkg::ADDR_STATUS, 32'h0, 4'h2, rs);
      refresh();
      a = 32'h7FF;
      for (int i = 0; i < 300 && a[10:0] >= 11'd96; i++) begin
         rd(iwdtw_pkg::ADDR_STATUS, a, rs);
      end
      refresh();
      rd(iwdtw_pkg::ADDR_STATUS, a, rs);
      chk("window refresh ok", 32'h1, {a[15], 31'(a[10:0] >= 11'd96)});
      // Early refresh stops the count so each code below starts clean
      refresh();
      wait_evt(20);
      chk("early refresh irq", 32'h2, {gi, gr});
      $display("test window done");
      for (int i = 0; i < 4; i++) begin
         wr(iwdtw_pkg::ADDR_CONTROL, 32'h3350 | i, 4'hF, rs);
         refresh();
         rd(iwdtw_pkg::ADDR_STATUS, a, rs);
         chk("initial count", 32'(tops[i]), a & 32'h7FF);
      end
      $display("test timeout codes done");
      wr(iwdtw_pkg::ADDR_CONTROL, 32'h3300, 4'hF, rs);
      wr(iwdtw_pkg::ADDR_STOPCTRL, 32'h80, 4'hF, rs);
      refresh();
      lowpower_mode <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("sleep stop", 32'h1, 32'(sleep_count_stop));
      stable(40);
      lowpower_mode <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("sleep stop off", 32'h0, 32'(sleep_count_stop));
      $display("test low power done");
      do_reset(16'h1F02);
      wait_evt(600);
      chk("auto reset event", 32'h1, {gi, gr});
      wait_evt(400);
      chk("stays stopped", 32'h0, {gi, gr});
      do_reset(16'h0F02);
      wait_evt(600);
      chk("auto irq event", 32'h2, {gi, gr});
      wait_evt(600);
      chk("auto restart", 32'h2, {gi, gr});
      $display("test auto start done");
      stop_test();
   end
endmodule
